// ### rtl/dcp_arb_if.sv
// Request and winner signals between the control block and one level arbiter
`timescale 1ns/10ps
`include "dcp_defines.svh"
interface dcp_arb_if;
   logic [`DCP_NUM_CH-1:0]     req;
   logic                       rr_en;
   logic [`DCP_PRI_LAST_W-1:0] last;
   logic                       win_valid;
   logic [`DCP_PRI_LAST_W-1:0] win_id;

   modport arb (input req, input rr_en, input last, output win_valid, output win_id);
   modport ctrl (output req, output rr_en, output last, input win_valid, input win_id);
endinterface

// ### rtl/dcp_ctrl.sv
// Global control of the DMA engine: debug run, bus QoS, soft triggers, level arbitration
//
// Summary of operation
// - Debug run bit survives software reset
// - Halted CPU stops engine unless run bit
// - Bits 5:4 give data transfer priority
// - Bits 3:2 give descriptor fetch priority
// - Bits 1:0 give write-back priority
// - QoS codes drive matching bus request priority
// - QoS register resets to 0x15
// - Trigger on idle channel sets pending only while engine runs
// - Trigger on pending channel is held
// - Held trigger clears when pending sets
// - Writing zero clears trigger, no request
// - Bits 31, 23 select static or round-robin
// - Round-robin records last granted channel
// - Static ignores recorded last channel
// - Leaving round-robin reloads recorded channel
// - Levels 1 and 0 at bits 15, 7
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "dcp_defines.svh"
module dcp_ctrl (
   input  wire logic                          clk_i,
   input  wire logic                          nrst_i,
   input  wire logic                          soft_rst_i,
   input  wire logic                          cpu_halted_i,
   input  wire logic                          hsel_i,
   input  wire logic [31:0]                   haddr_i,
   input  wire logic [1:0]                    htrans_i,
   input  wire logic                          hwrite_i,
   input  wire logic [2:0]                    hsize_i,
   input  wire logic [31:0]                   hwdata_i,
   input  wire logic                          hready_i,
   output logic      [31:0]                   hrdata_o,
   output logic                               hreadyout_o,
   output logic                               hresp_o,
   input  wire logic [`DCP_NUM_CH-1:0]        chan_pending_i,
   input  wire logic [`DCP_NUM_CH-1:0]        chan_req_i,
   input  wire logic [2*`DCP_NUM_CH-1:0]      chan_level_i,
   input  wire logic                          arb_enable_i,
   output logic      [`DCP_NUM_CH-1:0]        soft_trig_o,
   output logic                               grant_valid_o,
   output logic      [`DCP_PRI_LAST_W-1:0]    grant_ch_o,
   output logic      [1:0]                    grant_level_o,
   output logic                               engine_run_o,
   input  wire logic [1:0]                    bus_phase_i,
   output logic      [1:0]                    bus_qos_o,
   output logic      [1:0]                    data_phase_qos_o,
   output logic      [1:0]                    descriptor_fetch_qos_o,
   output logic      [1:0]                    writeback_phase_qos_o
);

   dcp_pkg::dcp_state_t s_reg;
   dcp_pkg::dcp_state_t s_next;

   logic                                   run;
   logic [`DCP_NUM_LVL-1:0]                lvl_vld;
   logic [`DCP_NUM_LVL*`DCP_PRI_LAST_W-1:0] lvl_id;

   // Halt request comes from the same clock domain, so no synchroniser
   assign run = s_reg.dbg_run | ~cpu_halted_i;

   dcp_arb_if arb [`DCP_NUM_LVL] ();

   for (genvar l = 0; l < `DCP_NUM_LVL; l++)
   begin : g_lvl
      for (genvar c = 0; c < `DCP_NUM_CH; c++)
      begin : g_req
         assign arb[l].req[c] = chan_req_i[c] && (chan_level_i[2*c +: 2] == 2'(l));
      end
      assign arb[l].rr_en = s_reg.rr_en[l];
      assign arb[l].last  = s_reg.last[l*`DCP_PRI_LAST_W +: `DCP_PRI_LAST_W];
      assign lvl_vld[l]   = arb[l].win_valid;
      assign lvl_id[l*`DCP_PRI_LAST_W +: `DCP_PRI_LAST_W] = arb[l].win_id;

      dcp_level_arb #(
         .NUM_CH (`DCP_NUM_CH)
      ) u_arb (
         .port (arb[l])
      );
   end

   function automatic logic [31:0] rd_word(input logic [`DCP_IDX_W-1:0] idx,
                                           input dcp_pkg::dcp_state_t st);
      logic [31:0] w;
      w = '0;
      case (idx)
         `DCP_IDX_DBG:    w[`DCP_DBG_RUN_BIT] = st.dbg_run;
         `DCP_IDX_QOS:    w[`DCP_QOS_W-1:0] = st.qos;
         `DCP_IDX_SWTRIG: w[`DCP_NUM_CH-1:0] = st.swtrig;
         `DCP_IDX_PRI:
         begin
            for (int l = 0; l < `DCP_NUM_LVL; l++)
            begin
               w[l*`DCP_PRI_STRIDE + `DCP_PRI_RR_POS] = st.rr_en[l];
               w[l*`DCP_PRI_STRIDE +: `DCP_PRI_LAST_W] =
                  st.last[l*`DCP_PRI_LAST_W +: `DCP_PRI_LAST_W];
            end
         end
         default: w = '0;
      endcase
      return w;
   endfunction

   always_comb
   begin
      s_next           = s_reg;
      s_next.trig      = '0;
      s_next.gnt_vld   = 1'b0;
      s_next.pend_prev = chan_pending_i;

      // Pending rising clears a held request; a same-cycle write of 1 still sets it
      for (int c = 0; c < `DCP_NUM_CH; c++)
      begin
         if (chan_pending_i[c] && !s_reg.pend_prev[c])
            s_next.swtrig[c] = 1'b0;
      end

      if (s_reg.wr_pend)
      begin
         case (s_reg.wr_idx)
            `DCP_IDX_DBG: s_next.dbg_run = hwdata_i[`DCP_DBG_RUN_BIT];
            `DCP_IDX_QOS: s_next.qos = hwdata_i[`DCP_QOS_W-1:0];
            `DCP_IDX_SWTRIG:
            begin
               for (int c = 0; c < `DCP_NUM_CH; c++)
               begin
                  if (!hwdata_i[c])
                     s_next.swtrig[c] = 1'b0;
                  else if (chan_pending_i[c] || !run)
                     s_next.swtrig[c] = 1'b1;
                  else
                  begin
                     s_next.swtrig[c] = 1'b0;
                     s_next.trig[c]   = 1'b1;
                  end
               end
            end
            `DCP_IDX_PRI:
            begin
               for (int l = 0; l < `DCP_NUM_LVL; l++)
               begin
                  s_next.rr_en[l] = hwdata_i[l*`DCP_PRI_STRIDE + `DCP_PRI_RR_POS];
                  s_next.last[l*`DCP_PRI_LAST_W +: `DCP_PRI_LAST_W] =
                     hwdata_i[l*`DCP_PRI_STRIDE +: `DCP_PRI_LAST_W];
               end
            end
            default: ;
         endcase
      end

      // Held bit keeps asking until pending rises; one pulse, then a cycle for pending to respond
      for (int c = 0; c < `DCP_NUM_CH; c++)
      begin
         if (s_next.swtrig[c] && !chan_pending_i[c] && !s_reg.trig[c] && run)
            s_next.trig[c] = 1'b1;
      end

      // Highest level with a winner takes the grant
      if (arb_enable_i && run)
      begin
         for (int l = 0; l < `DCP_NUM_LVL; l++)
         begin
            if (lvl_vld[l])
            begin
               s_next.gnt_vld = 1'b1;
               s_next.gnt_lvl = 2'(l);
               s_next.gnt_ch  = lvl_id[l*`DCP_PRI_LAST_W +: `DCP_PRI_LAST_W];
            end
         end
         // Static levels leave the recorded channel untouched
         if (s_next.gnt_vld && s_reg.rr_en[s_next.gnt_lvl])
            s_next.last[s_next.gnt_lvl*`DCP_PRI_LAST_W +: `DCP_PRI_LAST_W] = s_next.gnt_ch;
      end

      if (soft_rst_i)
      begin
         s_next.qos    = `DCP_QOS_RST;
         s_next.swtrig = `DCP_SWTRIG_RST;
         s_next.rr_en  = `DCP_RR_RST;
         s_next.last   = `DCP_LAST_RST;
         s_next.trig   = '0;
      end

      // Address phase; reads see this cycle's write so back-to-back access is coherent
      s_next.wr_pend = 1'b0;
      if (hsel_i && htrans_i[1] && hready_i)
      begin
         s_next.wr_pend = hwrite_i;
         s_next.wr_idx  = haddr_i[`DCP_IDX_W+1:2];
         if (!hwrite_i)
            s_next.rdata = rd_word(haddr_i[`DCP_IDX_W+1:2], s_next);
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_reg           <= '0;
         s_reg.dbg_run   <= `DCP_DBG_RST;
         s_reg.qos       <= `DCP_QOS_RST;
      end
      else
         s_reg <= s_next;
   end

   assign hrdata_o               = s_reg.rdata;
   assign hreadyout_o            = 1'b1;
   assign hresp_o                = 1'b0;
   assign soft_trig_o            = s_reg.trig;
   assign grant_valid_o          = s_reg.gnt_vld;
   assign grant_ch_o             = s_reg.gnt_ch;
   assign grant_level_o          = s_reg.gnt_lvl;
   assign engine_run_o           = run;
   assign data_phase_qos_o       = s_reg.qos[`DCP_QOS_DATA_LSB +: 2];
   assign descriptor_fetch_qos_o = s_reg.qos[`DCP_QOS_FETCH_LSB +: 2];
   assign writeback_phase_qos_o  = s_reg.qos[`DCP_QOS_WRB_LSB +: 2];

   always_comb
   begin
      case (bus_phase_i)
         `DCP_PH_DATA:  bus_qos_o = data_phase_qos_o;
         `DCP_PH_FETCH: bus_qos_o = descriptor_fetch_qos_o;
         `DCP_PH_WRB:   bus_qos_o = writeback_phase_qos_o;
         default:       bus_qos_o = dcp_pkg::DCP_QOS_BACKGROUND;
      endcase
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   logic wr_sw;
   logic wr_qos;
   logic wr_dbg;
   assign wr_sw  = s_reg.wr_pend && s_reg.wr_idx == `DCP_IDX_SWTRIG && !soft_rst_i;
   assign wr_qos = s_reg.wr_pend && s_reg.wr_idx == `DCP_IDX_QOS && !soft_rst_i;
   assign wr_dbg = s_reg.wr_pend && s_reg.wr_idx == `DCP_IDX_DBG;

   a_run_while_cpu_halted_soft_keep:
      assert property (soft_rst_i && !wr_dbg |=> s_reg.dbg_run == $past(s_reg.dbg_run))
      else $error("debug run bit lost on software reset");

   a_halt_no_grant:
      assert property (cpu_halted_i && !s_reg.dbg_run |=> !grant_valid_o && soft_trig_o == '0)
      else $error("engine active while halted");

   a_qos_data_field:
      assert property (wr_qos |=> data_phase_qos_o == $past(hwdata_i[5:4]))
      else $error("data qos not taken from bits 5:4");

   a_qos_fetch_field:
      assert property (wr_qos |=> ##1 descriptor_fetch_qos_o == $past(hwdata_i[3:2], 2))
      else $error("fetch qos not taken from bits 3:2");

   a_qos_wrb_field:
      assert property (wr_qos |=> writeback_phase_qos_o == $past(hwdata_i[1:0]))
      else $error("write-back qos not taken from bits 1:0");

   a_qos_bus_map:
      assert property (bus_phase_i == `DCP_PH_FETCH |-> bus_qos_o == s_reg.qos[3:2])
      else $error("bus qos does not follow fetch field");

   a_qos_soft_reset:
      assert property (soft_rst_i |=> s_reg.qos == 6'h15 && s_reg.swtrig == '0)
      else $error("qos register not back at reset value");

   a_trig_idle_chan:
      assert property (wr_sw && hwdata_i[0] && !chan_pending_i[0] && run
                       |=> soft_trig_o[0] && !s_reg.swtrig[0])
      else $error("idle channel trigger wrong");

   a_trig_held_pend:
      assert property (wr_sw && hwdata_i[0] && chan_pending_i[0] |=> s_reg.swtrig[0] && !soft_trig_o[0])
      else $error("trigger on pending channel not held");

   a_held_clear_rise:
      assert property (s_reg.swtrig[0] && chan_pending_i[0] && !s_reg.pend_prev[0] && !wr_sw
                       |=> !s_reg.swtrig[0])
      else $error("held trigger not cleared on pending");

   a_trig_write_zero:
      assert property (wr_sw && !hwdata_i[0] |=> !s_reg.swtrig[0] && !soft_trig_o[0])
      else $error("zero write did not clear trigger");

   a_rr_last_record:
      assert property (s_reg.gnt_vld && s_reg.rr_en[s_reg.gnt_lvl]
                       |-> s_reg.last[s_reg.gnt_lvl*4 +: 4] == s_reg.gnt_ch)
      else $error("round-robin last channel not recorded");

   a_static_lowest:
      assert property (grant_valid_o && !s_reg.rr_en[grant_level_o] && grant_ch_o != 4'h0
                       |-> !($past(chan_req_i[0]) && $past(chan_level_i[1:0]) == grant_level_o))
      else $error("static level skipped channel 0");

   c_trig_direct: cover property (wr_sw && hwdata_i[0] && !chan_pending_i[0] ##1 soft_trig_o[0]);
   c_trig_held:   cover property (s_reg.swtrig[0] ##[1:20] soft_trig_o[0]);
   c_rr_grant:    cover property (grant_valid_o && s_reg.rr_en[grant_level_o]);
   c_halt_stop:   cover property (cpu_halted_i && !s_reg.dbg_run && arb_enable_i && chan_req_i != '0);

endmodule

// ### rtl/dcp_defines.svh
// Register indices, field positions, reset values and encodings of the control block
`ifndef DCP_DEFINES_SVH
`define DCP_DEFINES_SVH

`define DCP_NUM_CH        12
`define DCP_NUM_LVL       4
`define DCP_IDX_W         6

// Register indices; byte address is four times the index
`define DCP_IDX_DBG       6'h0d
`define DCP_IDX_QOS       6'h0e
`define DCP_IDX_SWTRIG    6'h10
`define DCP_IDX_PRI       6'h14

`define DCP_DBG_RUN_BIT   0
`define DCP_QOS_DATA_LSB  4
`define DCP_QOS_FETCH_LSB 2
`define DCP_QOS_WRB_LSB   0
`define DCP_QOS_W         6
`define DCP_PRI_STRIDE    8
`define DCP_PRI_RR_POS    7
`define DCP_PRI_LAST_W    4

`define DCP_DBG_RST       1'h0
`define DCP_QOS_RST       6'h15
`define DCP_SWTRIG_RST    12'h000
`define DCP_RR_RST        4'h0
`define DCP_LAST_RST      16'h0000

// Bus phase codes on bus_phase_i
`define DCP_PH_DATA       2'h0
`define DCP_PH_FETCH      2'h1
`define DCP_PH_WRB        2'h2

`endif

// ### rtl/dcp_level_arb.sv
// Winner selection among the requesting channels of one priority level
`timescale 1ns/10ps
`include "dcp_defines.svh"
module dcp_level_arb #(
   parameter int NUM_CH = `DCP_NUM_CH
)(
   dcp_arb_if.arb port
);

   // Channel numbers must fit the recorded-channel field
   if (NUM_CH < 1 || NUM_CH > (1 << `DCP_PRI_LAST_W))
   begin : g_bad_num_ch
      $error("dcp_level_arb: NUM_CH out of range");
   end

   // Search starts just after base; static uses the top channel so channel 0 comes first
   function automatic logic [`DCP_PRI_LAST_W:0] pick(input logic [NUM_CH-1:0] req,
                                                     input logic rr,
                                                     input logic [`DCP_PRI_LAST_W-1:0] last);
      int                       base;
      int                       idx;
      logic [`DCP_PRI_LAST_W:0] res;
      base = rr ? int'(last) : NUM_CH - 1;
      res = '0;
      for (int i = NUM_CH; i >= 1; i--)
      begin
         idx = (base + i) % NUM_CH;
         if (req[idx])
            res = {1'b1, idx[`DCP_PRI_LAST_W-1:0]};
      end
      return res;
   endfunction

   logic [`DCP_PRI_LAST_W:0] sel;

   assign sel            = pick(port.req[NUM_CH-1:0], port.rr_en, port.last);
   assign port.win_valid = sel[`DCP_PRI_LAST_W];
   assign port.win_id    = sel[`DCP_PRI_LAST_W-1:0];

endmodule

// ### rtl/dcp_pkg.sv
// Types used by the control block: QoS codes and register state
`include "dcp_defines.svh"
package dcp_pkg;

   typedef enum logic [1:0] {
      DCP_QOS_BACKGROUND = 2'h0,
      DCP_QOS_BANDWIDTH  = 2'h1,
      DCP_QOS_LATENCY    = 2'h2,
      DCP_QOS_CRITICAL   = 2'h3
   } dcp_qos_t;

   typedef struct packed {
      logic                                         dbg_run;
      logic [`DCP_QOS_W-1:0]                        qos;
      logic [`DCP_NUM_CH-1:0]                       swtrig;
      logic [`DCP_NUM_LVL-1:0]                      rr_en;
      logic [`DCP_NUM_LVL*`DCP_PRI_LAST_W-1:0]      last;
      logic [`DCP_NUM_CH-1:0]                       pend_prev;
      logic [`DCP_NUM_CH-1:0]                       trig;
      logic                                         wr_pend;
      logic [`DCP_IDX_W-1:0]                        wr_idx;
      logic [31:0]                                  rdata;
      logic                                         gnt_vld;
      logic [`DCP_PRI_LAST_W-1:0]                   gnt_ch;
      logic [1:0]                                   gnt_lvl;
   } dcp_state_t;

endpackage

// ### sim/dcp_chan_model.sv
// Channel side model: pending flags raised by soft triggers
`timescale 1ns/10ps
`include "dcp_defines.svh"
module dcp_chan_model (
   input  wire logic                   clk_i,
   input  wire logic                   nrst_i,
   input  wire logic [`DCP_NUM_CH-1:0] soft_trig_i,
   input  wire logic [`DCP_NUM_CH-1:0] clear_i,
   output logic      [`DCP_NUM_CH-1:0] pending_o
);
   // Trigger wins over a same-cycle clear, as a real channel would latch it
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         pending_o <= '0;
      else
         pending_o <= (pending_o & ~clear_i) | soft_trig_i;
   end
endmodule

// ### sim/test_dma_ctrl_qos_trigger_priority.sv
// Register-level bench of the DMA global control block
`timescale 1ns/10ps
`include "dcp_defines.svh"
module test_dma_ctrl_qos_trigger_priority;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        soft_rst_i = 1'b0;
   logic        cpu_halted_i = 1'b0;
   logic        hsel_i = 1'b0;
   logic [31:0] haddr_i = 32'h0;
   logic [1:0]  htrans_i = 2'h0;
   logic        hwrite_i = 1'b0;
   logic [31:0] hwdata_i = 32'h0;
   logic [31:0] hrdata_o;
   logic        hreadyout_o;
   logic        hresp_o;
   logic [11:0] pend;
   logic [11:0] clr = 12'h0;
   logic [11:0] req = 12'h0;
   logic [23:0] lvl = 24'h0;
   logic        arb_en = 1'b0;
   logic [11:0] soft_trig_o;
   logic        grant_valid_o;
   logic [3:0]  grant_ch_o;
   logic [1:0]  grant_level_o;
   logic        engine_run_o;
   logic [1:0]  phase = 2'h0;
   logic [1:0]  bus_qos_o;
   logic [1:0]  dq;
   logic [1:0]  fq;
   logic [1:0]  wq;
   logic [31:0] rd;
   int          failures = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          pulses = 0;

   always #20 clk_i = ~clk_i;

   dcp_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .soft_rst_i(soft_rst_i), .cpu_halted_i(cpu_halted_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .chan_pending_i(pend), .chan_req_i(req), .chan_level_i(lvl), .arb_enable_i(arb_en),
      .soft_trig_o(soft_trig_o), .grant_valid_o(grant_valid_o), .grant_ch_o(grant_ch_o),
      .grant_level_o(grant_level_o), .engine_run_o(engine_run_o), .bus_phase_i(phase), .bus_qos_o(bus_qos_o),
      .data_phase_qos_o(dq), .descriptor_fetch_qos_o(fq), .writeback_phase_qos_o(wq));

   dcp_chan_model u_chan (.clk_i(clk_i), .nrst_i(nrst_i), .soft_trig_i(soft_trig_o), .clear_i(clr),
      .pending_o(pend));

   // Counts issued triggers on channel 0 so missing or extra pulses show
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (soft_trig_o[0] === 1'b1)
         pulses <= pulses + 1;
      if (cycles == 6000)
      begin
         failures = failures + 1;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
      chk({31'h0, hresp_o}, 32'h0);
   endtask

   // Two requesters for one arbitration cycle; the grant follows one cycle later
   task automatic arb(input int a, input logic [1:0] la, input int b, input logic [1:0] lb,
                      input logic [3:0] ech, input logic [1:0] elv);
      @(posedge clk_i);
      lvl <= (24'(la) << (2 * a)) | (24'(lb) << (2 * b));
      req <= (12'h1 << a) | (12'h1 << b);
      arb_en <= 1'b1;
      @(posedge clk_i);
      arb_en <= 1'b0;
      req <= 12'h0;
      #1;
      chk({31'h0, grant_valid_o}, 32'h1);
      chk({26'h0, grant_level_o, grant_ch_o}, {26'h0, elv, ech});
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      rdchk(32'h34, 32'h0);
      rdchk(32'h38, 32'h15);
      rdchk(32'h40, 32'h0);
      rdchk(32'h50, 32'h0);
      rdchk(32'h3c, 32'h0);
      chk({30'h0, dq & fq & wq}, 32'h1);
      // Each code lands in each phase field once across the loop
      for (int c = 0; c < 4; c++)
      begin
         bus(32'h38, 1'b1, 32'(c * 16 + ((c + 1) % 4) * 4 + (c + 2) % 4));
         for (int p = 0; p < 4; p++)
         begin
            phase <= 2'(p);
            @(posedge clk_i);
            #1;
            chk({30'h0, bus_qos_o}, (p == 3) ? 32'h0 : 32'((c + p) % 4));
         end
         chk({26'h0, dq, fq, wq}, 32'(c * 16 + ((c + 1) % 4) * 4 + (c + 2) % 4));
      end
      bus(32'h40, 1'b1, 32'h1);
      repeat (3) @(posedge clk_i);
      chk(32'(pulses), 32'h1);
      rdchk(32'h40, 32'h0);
      bus(32'h40, 1'b1, 32'h1);
      rdchk(32'h40, 32'h1);
      bus(32'h40, 1'b1, 32'h0);
      rdchk(32'h40, 32'h0);
      chk(32'(pulses), 32'h1);
      bus(32'h40, 1'b1, 32'h1);
      @(posedge clk_i);
      clr <= 12'h1;
      @(posedge clk_i);
      clr <= 12'h0;
      repeat (4) @(posedge clk_i);
      chk(32'(pulses), 32'h2);
      rdchk(32'h40, 32'h0);
      for (int l = 0; l < 4; l++)
      begin
         bus(32'h50, 1'b1, 32'h2 << (8 * l));
         arb(2, 2'(l), 9, 2'(l), 4'h2, 2'(l));
         bus(32'h50, 1'b1, 32'h82 << (8 * l));
         arb(2, 2'(l), 9, 2'(l), 4'h9, 2'(l));
         rdchk(32'h50, 32'h89 << (8 * l));
         arb(2, 2'(l), 9, 2'(l), 4'h2, 2'(l));
         rdchk(32'h50, 32'h82 << (8 * l));
      end
      arb(1, 2'h1, 3, 2'h3, 4'h3, 2'h3);
      @(posedge clk_i);
      cpu_halted_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk({31'h0, engine_run_o}, 32'h0);
      @(posedge clk_i);
      req <= 12'h10;
      arb_en <= 1'b1;
      @(posedge clk_i);
      req <= 12'h0;
      arb_en <= 1'b0;
      #1;
      chk({31'h0, grant_valid_o}, 32'h0);
      bus(32'h40, 1'b1, 32'h2);
      rdchk(32'h40, 32'h2);
      bus(32'h34, 1'b1, 32'h1);
      #1;
      chk({31'h0, engine_run_o}, 32'h1);
      bus(32'h38, 1'b1, 32'h2a);
      #1;
      chk({26'h0, dq, fq, wq}, 32'h2a);
      @(posedge clk_i);
      soft_rst_i <= 1'b1;
      @(posedge clk_i);
      soft_rst_i <= 1'b0;
      rdchk(32'h34, 32'h1);
      rdchk(32'h38, 32'h15);
      // Power-up reset mid-run must clear the run bit again
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      rdchk(32'h34, 32'h0);
      #1;
      chk({31'h0, engine_run_o}, 32'h0);
      summarize();
   end
endmodule
